// ---- design/tmr_pkg.sv ----
// Purpose: Constants and types for the 16-bit timer/counter with crystal oscillator
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Byte registers sit in the low bits of their word; upper bits read as zero
package tmr_pkg;
  // Register byte addresses
  localparam logic [4:0] TMR_OFS_CONTROL = 5'h00;
  localparam logic [4:0] TMR_OFS_COUNT_LOW = 5'h04;
  localparam logic [4:0] TMR_OFS_COUNT_HIGH = 5'h08;
  localparam logic [4:0] TMR_OFS_IRQ_FLAGS = 5'h0C;
  localparam logic [4:0] TMR_OFS_IRQ_ENABLES = 5'h10;
  localparam logic [4:0] TMR_OFS_OSC_CONTROL = 5'h14;
  // Field positions
  localparam int TMR_BIT_OVERFLOW = 0;
  localparam int TMR_BIT_IDLE_ON_SLEEP = 7;
  localparam int TMR_BIT_OSC_LOW_POWER = 6;
  localparam int TMR_BIT_SECONDARY_IDLE_MODE = 3;
  localparam int TMR_BIT_SECONDARY_RUN_MODE = 2;
  // Reset values and the LP oscillator clock select code
  localparam logic [7:0] TMR_RST_CONTROL = 8'h00;
  localparam logic [15:0] TMR_RST_COUNT = 16'h0000;
  localparam logic [1:0] TMR_SCS_LP_OSC = 2'h1;
  // Prescale codes and dividers
  localparam logic [1:0] TMR_PS_DIV1 = 2'h0;
  localparam logic [1:0] TMR_PS_DIV2 = 2'h1;
  localparam logic [1:0] TMR_PS_DIV4 = 2'h2;
  localparam logic [1:0] TMR_PS_DIV8 = 2'h3;
  localparam logic [2:0] TMR_PS_LAST1 = 3'h0;
  localparam logic [2:0] TMR_PS_LAST2 = 3'h1;
  localparam logic [2:0] TMR_PS_LAST4 = 3'h3;
  localparam logic [2:0] TMR_PS_LAST8 = 3'h7;
  localparam logic [15:0] TMR_COUNT_MAX = 16'hFFFF;
  // AXI responses
  localparam logic [1:0] TMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR_RESP_SLVERR = 2'h2;

  // Timer control register layout, msb first
  typedef struct packed {
    logic buffered_access_enable;
    logic osc_clock_status;
    logic [1:0] input_prescale_select;
    logic lp_osc_enable;
    logic ext_sync_disable;
    logic count_source_select;
    logic counter_run;
  } tmr_ctrl_t;

  // Oscillator control register, own fields
  typedef struct packed {
    logic idle_on_sleep;
    logic osc_low_power_cfg;
    logic [1:0] system_clock_select;
  } tmr_osc_t;
endpackage

// ---- design/tmr_timer.sv ----
// Purpose: 16-bit up counter with prescaler, buffered access, overflow flag, LP oscillator
// Assumes: aclk at 100 MHz is the instruction clock; pins are synchronous to aclk
// Notes: Registers over AXI4-Lite; one write and one read in flight at most
// What this block does
// - Counter advances only while counter_run is set; clearing it holds the value.
// - buffered_access_enable picks coherent 16-bit access or independent byte access.
// - osc_clock_status reads 1 only when system clock comes from LP oscillator.
// - Prescale code 11 divides by 8, 10 by 4, 01 by 2, 00 by 1.
// - lp_osc_enable turns the crystal oscillator on, clear shuts it off.
// - External source: ext_sync_disable 0 synchronises, 1 counts unsynchronised edges.
// - Internal source ignores ext_sync_disable and counts the instruction clock.
// - Source select 0 counts every cycle; 1 counts rising external or oscillator edges.
// - While running, both oscillator pins are forced inputs and read as zero.
// - Buffered mode: high-byte address reaches a holding buffer, not the counter.
// - Buffered mode: reading low byte copies live high byte into holding buffer.
// - Buffered mode: writing low byte loads live high byte from the buffer together.
// - High-byte writes keep the prescaler; only low-byte writes clear it.
// - Count wraps FFFF to 0000 and sets the sticky overflow flag.
// - Overflow interrupt leaves the block only when its enable bit is set.
// - Status bit follows the actual clock source, including a fail-safe switch away.
// - Once enabled the oscillator keeps running through every power-managed mode.
// - System clock select 01 with lp_osc_enable set and no osc_failed runs from the oscillator; sleep gives idle only while idle_on_sleep is clear.
// - osc_low_power_cfg selects the lower oscillator drive level when set.
module tmr_timer
  import tmr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [4:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [4:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // Count pins and oscillator
  input wire logic ext_count_clock_pin,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  output logic osc_amp_enable,
  output logic osc_low_power_drive,
  // Port pin direction override
  input wire logic [1:0] port_c_direction,
  output logic [1:0] port_pin_dir_effective,
  output logic port_pin_read_zero,
  // System clock and power state
  input wire logic sleep_req,
  input wire logic osc_failed,
  output logic sys_clk_from_osc,
  output logic secondary_run_mode,
  output logic secondary_idle_mode,
  output logic overflow_irq
);
  import tmr_pkg::*;

  tmr_ctrl_t ctrl;
  tmr_osc_t osc;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic [2:0] prescale_cnt;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic raw_prev;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic [1:0] bresp;
  logic bvalid;

  // Bus handshake: a write is taken only with address and data together
  wire wr_go = s_axil_awvalid && s_axil_wvalid && !bvalid;
  wire rd_go = s_axil_arvalid && !rvalid;
  wire wr_lane0 = wr_go && s_axil_wstrb[0];
  wire [7:0] wbyte = s_axil_wdata[7:0];

  // Write address decode
  wire wr_ctrl = wr_lane0 && (s_axil_awaddr == TMR_OFS_CONTROL);
  wire wr_low = wr_lane0 && (s_axil_awaddr == TMR_OFS_COUNT_LOW);
  wire wr_high = wr_lane0 && (s_axil_awaddr == TMR_OFS_COUNT_HIGH);
  wire wr_flags = wr_lane0 && (s_axil_awaddr == TMR_OFS_IRQ_FLAGS);
  wire wr_enables = wr_lane0 && (s_axil_awaddr == TMR_OFS_IRQ_ENABLES);
  wire wr_osc = wr_lane0 && (s_axil_awaddr == TMR_OFS_OSC_CONTROL);
  wire wr_mapped = (s_axil_awaddr == TMR_OFS_CONTROL) || (s_axil_awaddr == TMR_OFS_COUNT_LOW)
    || (s_axil_awaddr == TMR_OFS_COUNT_HIGH) || (s_axil_awaddr == TMR_OFS_IRQ_FLAGS)
    || (s_axil_awaddr == TMR_OFS_IRQ_ENABLES) || (s_axil_awaddr == TMR_OFS_OSC_CONTROL);

  // Read address decode
  wire rd_low = rd_go && (s_axil_araddr == TMR_OFS_COUNT_LOW);

  // Clock status tracks the source really in use, so a fail-safe switch clears it
  wire osc_clock_live = (osc.system_clock_select == TMR_SCS_LP_OSC) && ctrl.lp_osc_enable
    && !osc_failed;

  // Count source: oscillator input replaces the pin when enabled
  wire ext_raw = ctrl.lp_osc_enable ? crystal_in_pin : ext_count_clock_pin;
  wire sync_rise = sync_b && !sync_prev;
  wire async_rise = ext_raw && !raw_prev;
  wire ext_edge = ctrl.ext_sync_disable ? async_rise : sync_rise;
  wire src_tick = ctrl.count_source_select ? ext_edge : 1'b1;
  wire count_tick_in = ctrl.counter_run && src_tick;

  // Prescale terminal count per code
  wire [2:0] ps_last = (ctrl.input_prescale_select == TMR_PS_DIV8) ? TMR_PS_LAST8 :
    (ctrl.input_prescale_select == TMR_PS_DIV4) ? TMR_PS_LAST4 :
    (ctrl.input_prescale_select == TMR_PS_DIV2) ? TMR_PS_LAST2 : TMR_PS_LAST1;
  wire ps_done = count_tick_in && (prescale_cnt >= ps_last);
  wire [2:0] next_prescale = wr_low ? 3'h0 : ps_done ? 3'h0 :
    count_tick_in ? prescale_cnt + 3'h1 : prescale_cnt;

  // Counter next value; a low-byte write overrides the increment of that cycle, a direct high-byte write replaces only the high byte
  wire [15:0] count_inc = ps_done ? count + 16'h0001 : count;
  wire wrap = ps_done && (count == TMR_COUNT_MAX);
  wire [7:0] low_write_high = ctrl.buffered_access_enable ? high_buffer : count[15:8];
  wire [15:0] next_count = wr_low ? {low_write_high, wbyte} :
    (wr_high && !ctrl.buffered_access_enable) ? {wbyte, count_inc[7:0]} : count_inc;

  // Holding buffer: written at high address, refreshed on low-byte read
  wire [7:0] next_high_buffer = (wr_high && ctrl.buffered_access_enable) ? wbyte :
    (rd_low && ctrl.buffered_access_enable) ? count[15:8] : high_buffer;

  // Overflow flag: hardware set wins over a software clear in the same cycle
  wire next_flag = wrap ? 1'b1 : wr_flags ? wbyte[TMR_BIT_OVERFLOW] : overflow_flag;

  // Read data mux
  wire [7:0] rd_ctrl = {ctrl.buffered_access_enable, osc_clock_live,
    ctrl.input_prescale_select, ctrl.lp_osc_enable, ctrl.ext_sync_disable,
    ctrl.count_source_select, ctrl.counter_run};
  wire [7:0] rd_osc = {osc.idle_on_sleep, osc.osc_low_power_cfg, 2'h0,
    secondary_idle_mode, secondary_run_mode, osc.system_clock_select};
  wire [7:0] rd_high = ctrl.buffered_access_enable ? high_buffer : count[15:8];
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (s_axil_araddr == TMR_OFS_CONTROL) begin
      rd_byte = rd_ctrl;
    end else if (s_axil_araddr == TMR_OFS_COUNT_LOW) begin
      rd_byte = count[7:0];
    end else if (s_axil_araddr == TMR_OFS_COUNT_HIGH) begin
      rd_byte = rd_high;
    end else if (s_axil_araddr == TMR_OFS_IRQ_FLAGS) begin
      rd_byte = {7'h00, overflow_flag};
    end else if (s_axil_araddr == TMR_OFS_IRQ_ENABLES) begin
      rd_byte = {7'h00, overflow_irq_enable};
    end else if (s_axil_araddr == TMR_OFS_OSC_CONTROL) begin
      rd_byte = rd_osc;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Control and oscillator registers; the status bit is never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tmr_ctrl_t'(TMR_RST_CONTROL);
      osc <= '0;
      overflow_irq_enable <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl <= tmr_ctrl_t'(wbyte);
        ctrl.osc_clock_status <= 1'b0;
      end
      if (wr_enables) begin
        overflow_irq_enable <= wbyte[TMR_BIT_OVERFLOW];
      end
      if (wr_osc) begin
        osc <= {wbyte[TMR_BIT_IDLE_ON_SLEEP], wbyte[TMR_BIT_OSC_LOW_POWER], wbyte[1:0]};
      end
    end
  end

  // Counter, buffer, prescaler and flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= TMR_RST_COUNT;
      high_buffer <= 8'h00;
      prescale_cnt <= 3'h0;
      overflow_flag <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      high_buffer <= next_high_buffer;
      prescale_cnt <= next_prescale;
      overflow_flag <= next_flag;
    end
  end

  // Two-flop synchroniser; only sync_b feeds the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
      raw_prev <= 1'b0;
    end else if (clk_en) begin
      sync_a <= ext_raw;
      sync_b <= sync_a;
      sync_prev <= sync_b;
      raw_prev <= ext_raw;
    end
  end

  // Write response, one cycle after the write is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= TMR_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? TMR_RESP_OKAY : TMR_RESP_SLVERR;
      end else if (s_axil_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read response, data registered at the address hand-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= TMR_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_hit ? TMR_RESP_OKAY : TMR_RESP_SLVERR;
      end else if (s_axil_rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Bus outputs; ready terms stall while clock enable is low
  assign s_axil_awready = wr_go && clk_en;
  assign s_axil_wready = wr_go && clk_en;
  assign s_axil_arready = rd_go && clk_en;
  assign s_axil_bvalid = bvalid;
  assign s_axil_bresp = bresp;
  assign s_axil_rvalid = rvalid;
  assign s_axil_rdata = rdata;
  assign s_axil_rresp = rresp;

  // Oscillator drive ignores sleep so it survives power-managed modes
  assign osc_amp_enable = ctrl.lp_osc_enable;
  assign crystal_out_pin = ctrl.lp_osc_enable && !crystal_in_pin;
  assign osc_low_power_drive = osc.osc_low_power_cfg;

  // Running timer owns both pins as inputs
  assign port_pin_dir_effective = ctrl.counter_run ? 2'h3 : port_c_direction;
  assign port_pin_read_zero = ctrl.counter_run;

  // Power-managed clocking from the oscillator
  assign sys_clk_from_osc = osc_clock_live;
  assign secondary_run_mode = osc_clock_live && !sleep_req;
  assign secondary_idle_mode = osc_clock_live && sleep_req && !osc.idle_on_sleep;
  assign overflow_irq = overflow_flag && overflow_irq_enable;
endmodule // tmr_timer

// ---- tb/tmr_pin_model.sv ----
// Purpose: Far-side clock sources, external count pin and crystal line
// Assumes: Edges are slow against aclk
// Notes: Both lines rest low between bursts, so no stray edge is counted
module tmr_pin_model (
  input wire logic aclk,
  output logic ext_count_clock_pin,
  output logic crystal_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ext_count_clock_pin, crystal_in_pin} = 2'h0;
  // Send n rising edges on the crystal line or the external pin
  task automatic burst(input int n, input logic xtal);
    repeat (n) begin
      repeat (3) @(posedge aclk);
      if (xtal) crystal_in_pin <= 1'b1;
      else ext_count_clock_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      {ext_count_clock_pin, crystal_in_pin} <= 2'h0;
    end
  endtask
endmodule // tmr_pin_model

// ---- tb/tmr_chk.sv ----
// Purpose: Port assertions for the timer block
// Assumes: One clock domain, aresetn synchronous active low
// Notes: Bound to every timer instance
module tmr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_pin_dir_effective,
  input wire logic port_pin_read_zero,
  input wire logic sleep_req,
  input wire logic osc_failed,
  input wire logic sys_clk_from_osc,
  input wire logic secondary_run_mode,
  input wire logic secondary_idle_mode,
  input wire logic crystal_in_pin,
  input wire logic crystal_out_pin,
  input wire logic osc_amp_enable,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic [31:0] s_axil_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Everything samples on aclk and rests during reset
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin override, power-mode decode and crystal drive
  property p_pin_dir;
    port_pin_dir_effective == (port_pin_read_zero ? 2'h3 : port_c_direction);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");
  property p_secondary_run_mode; secondary_run_mode == (sys_clk_from_osc && !sleep_req); endproperty
  a_secondary_run_mode: assert property (p_secondary_run_mode) else $error("run mode wrong");
  property p_secondary_idle_mode; secondary_idle_mode |-> sys_clk_from_osc && sleep_req; endproperty
  a_secondary_idle_mode: assert property (p_secondary_idle_mode) else $error("idle mode wrong");
  property p_fail; osc_failed |-> !sys_clk_from_osc; endproperty
  a_fail: assert property (p_fail) else $error("clock status after failure");
  property p_xout; crystal_out_pin |-> osc_amp_enable && !crystal_in_pin; endproperty
  a_xout: assert property (p_xout) else $error("crystal drive wrong");
  // Bus answers come one cycle after the take, upper read bits clear
  property p_wr_ans; s_axil_awvalid && s_axil_awready |=> s_axil_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_axil_arvalid && s_axil_arready |-> ##1 s_axil_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_clean; $rose(s_axil_rvalid) |-> s_axil_rdata[31:8] == 24'h0; endproperty
  a_rd_clean: assert property (p_rd_clean) else $error("read upper bits set");
  c_idle: cover property (secondary_idle_mode);
  c_xout: cover property (crystal_out_pin);
  c_run: cover property (port_pin_read_zero && port_c_direction == 2'h0);
endmodule // tmr_chk
bind tmr_timer tmr_chk u_chk (.*);

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the timer block
// Assumes: 100 MHz aclk, reads answered in order
// Notes: Read expectations are queued by the driver and matched by a monitor
module tb;
  import tmr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  logic aclk, aresetn, clk_en, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic s_axil_rready, ext_count_clock_pin, crystal_in_pin, crystal_out_pin, osc_amp_enable;
  logic osc_low_power_drive, port_pin_read_zero, sleep_req, osc_failed, sys_clk_from_osc;
  logic secondary_run_mode, secondary_idle_mode, overflow_irq;
  logic [4:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, port_c_direction, port_pin_dir_effective;
  logic [33:0] exp_q[$];
  logic [33:0] e_word;
  logic [7:0] d;
  int num_errors, checks_done;
  int seed = 27236;
  tmr_timer DUT (.*);
  tmr_pin_model u_pins (.*);
  always #5ns aclk = ~aclk;
  // Random direction bits and sleep requests keep the mode logic busy
  always @(posedge aclk) begin
    port_c_direction <= 2'($random(seed));
    sleep_req <= 1'($random(seed));
  end
  // Each read answer is matched against the oldest expectation
  always @(posedge aclk) begin
    if (s_axil_rvalid && s_axil_rready) begin
      e_word = exp_q.pop_front();
      `CHK("read", e_word, {s_axil_rresp, s_axil_rdata})
    end
  end
  // Write one register; address and data travel together
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h0, v};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axil_awready && s_axil_wready));
    s_axil_awvalid <= 1'b0;
    s_axil_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_bvalid);
  endtask
  // Read one register and queue what it should return
  task automatic rd(input logic [4:0] a, input logic [7:0] v, input logic [1:0] r = TMR_RESP_OKAY);
    exp_q.push_back({r, 24'h0, v});
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axil_rvalid);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the several hundred cycles the run needs
  initial begin
    #200us;
    num_errors++;
    wrap_up;
  end
  initial begin
    aclk = 1'b0;
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_arvalid, osc_failed} = 5'h00;
    {clk_en, s_axil_bready, s_axil_rready} = 3'h7;
    s_axil_wstrb = 4'hF;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 42'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped address, live bytes while stopped
    rd(TMR_OFS_CONTROL, TMR_RST_CONTROL);
    rd(5'h18, 8'h00, TMR_RESP_SLVERR);
    d = 8'($random(seed));
    wr(TMR_OFS_COUNT_LOW, d);
    wr(TMR_OFS_COUNT_HIGH, ~d);
    rd(TMR_OFS_COUNT_LOW, d);
    rd(TMR_OFS_COUNT_HIGH, ~d);
    // Buffered mode: high address holds a buffer loaded by low accesses
    wr(TMR_OFS_CONTROL, 8'h80);
    wr(TMR_OFS_COUNT_HIGH, 8'h5A);
    rd(TMR_OFS_COUNT_HIGH, 8'h5A);
    wr(TMR_OFS_COUNT_LOW, 8'h3C);
    wr(TMR_OFS_COUNT_HIGH, 8'h77);
    rd(TMR_OFS_COUNT_LOW, 8'h3C);
    rd(TMR_OFS_COUNT_HIGH, 8'h5A);
    wr(TMR_OFS_CONTROL, 8'h00);
    rd(TMR_OFS_COUNT_HIGH, 8'h5A);
    // Every prescale code, pin and crystal, synced and not
    for (int c = 0; c < 4; c++) begin
      wr(TMR_OFS_CONTROL, 8'h00);
      wr(TMR_OFS_COUNT_HIGH, 8'h00);
      wr(TMR_OFS_COUNT_LOW, 8'h00);
      wr(TMR_OFS_CONTROL, {2'h0, 2'(c), c[1], c[0], 2'h3});
      repeat (20) @(posedge aclk);
      u_pins.burst(16, c[1]);
      repeat (8) @(posedge aclk);
      rd(TMR_OFS_COUNT_LOW, 8'(16 >> c));
    end
    // Wrap from FFFF sets the sticky flag; the enable gates the request
    wr(TMR_OFS_CONTROL, 8'h00);
    wr(TMR_OFS_COUNT_HIGH, 8'hFF);
    wr(TMR_OFS_COUNT_LOW, 8'hFF);
    wr(TMR_OFS_CONTROL, 8'h05);
    repeat (20) @(posedge aclk);
    wr(TMR_OFS_CONTROL, 8'h00);
    rd(TMR_OFS_COUNT_HIGH, 8'h00);
    rd(TMR_OFS_IRQ_FLAGS, 8'h01);
    `CHK("irq", 1'b0, overflow_irq)
    wr(TMR_OFS_IRQ_ENABLES, 8'h01);
    `CHK("irq", 1'b1, overflow_irq)
    wr(TMR_OFS_IRQ_FLAGS, 8'h00);
    rd(TMR_OFS_IRQ_FLAGS, 8'h00);
    `CHK("irq", 1'b0, overflow_irq)
    // Crystal as system clock: status bit, fail-safe, drive level
    wr(TMR_OFS_OSC_CONTROL, 8'h41);
    wr(TMR_OFS_CONTROL, 8'h48);
    rd(TMR_OFS_CONTROL, 8'h48);
    `CHK("drive", 1'b1, osc_low_power_drive)
    `CHK("amp", 1'b1, osc_amp_enable)
    osc_failed <= 1'b1;
    rd(TMR_OFS_CONTROL, 8'h08);
    rd(TMR_OFS_OSC_CONTROL, 8'h41);
    wr(TMR_OFS_CONTROL, 8'h40);
    rd(TMR_OFS_CONTROL, 8'h00);
    `CHK("amp", 1'b0, osc_amp_enable)
    wrap_up;
  end
endmodule // tb
